//--- usb_suspend_wakeup_control.sv
// Behaviour
// - On detecting suspend signalling on the bus the device enters suspend.
// - Entering suspend asserts both suspend indicators.
// - After any device reset the indicators stay asserted until configuration and enumeration end.
// - The active-high indicator is high while suspended and low in normal operation.
// - The second indicator always carries the inverse of the active-high indicator.
// - Suspend ends on resume detected or generated, on bus reset, or on device reset.
// - Suspend also ends when enabled wakeup pins stop equalling their match values.
// - During device reset both indicators float, weakly pulled toward the I/O supply.
// - Every general-purpose pin can be enabled individually as a wakeup source.
// - While suspended, a mismatch on an enabled wakeup pin sends remote wakeup to the host if CTRL_REMOTE_WAKE is set.
// - Each pin's suspend level and drive type come from one-time programmable configuration.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module usb_suspend_wakeup_control
    import suspend_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      arst_n_i,
    // Bus signalling events from the USB core and the wakeup request back to it
    input  wire logic                      bus_suspend_i,
    input  wire logic                      bus_resume_i,
    input  wire logic                      bus_reset_i,
    input  wire logic                      enum_done_i,
    output logic                           remote_wake_o,
    // General-purpose pins
    input  wire logic [GPIO_COUNT-1:0]     gpio_i,
    input  wire logic [GPIO_COUNT-1:0]     gpio_normal_i,
    input  wire logic [GPIO_COUNT-1:0]     gpio_normal_oe_i,
    output logic      [GPIO_COUNT-1:0]     gpio_o,
    output logic      [GPIO_COUNT-1:0]     gpio_oe_o,
    // Suspend indicators, two signals each
    output logic                           suspend_o,
    output logic                           suspend_oe_o,
    output logic                           suspend_n_o,
    output logic                           suspend_n_oe_o,
    // Register port
    input  wire logic [3:0]                reg_addr_i,
    input  wire logic [31:0]               reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [31:0]               reg_rdata_o,
    // Interrupt
    output logic                           irq_o
);

    logic                  rst_sync1;
    logic                  rst_n;
    susp_state_t           state;
    susp_state_t           next_state;
    logic                  config_done;
    logic                  remote_wake_en;
    logic [GPIO_COUNT-1:0] wake_enable;
    logic [GPIO_COUNT-1:0] wake_match;
    logic [GPIO_COUNT-1:0] susp_level;
    logic [GPIO_COUNT-1:0] susp_od;
    logic [GPIO_COUNT-1:0] mismatch_bits;
    logic                  wake_mismatch;
    logic [IRQ_WIDTH-1:0]  irq_status;
    logic [IRQ_WIDTH-1:0]  irq_enable;
    logic [IRQ_WIDTH-1:0]  irq_events;
    logic                  suspended;
    logic                  next_suspended;
    logic                  wr_clear;
    logic                  wr_control;
    logic                  wr_wake_enable;
    logic                  wr_wake_match;
    logic                  wr_susp_level;
    logic                  wr_susp_od;
    logic                  wr_irq_enable;
    logic [31:0]           next_rdata;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync1 <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n     <= rst_sync1;
        end
    end

    // Per-pin mismatch, masked by each pin's own enable
    // A pin with its enable clear never wakes the device, whatever its level
    genvar g;
    generate
        for (g = 0; g < GPIO_COUNT; g++) begin : g_mis
            assign mismatch_bits[g] = wake_enable[g] & (gpio_i[g] ^ wake_match[g]);
        end
    endgenerate
    assign wake_mismatch = |mismatch_bits;

    // Suspend state sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_UNCONFIGURED: begin
                if (config_done && enum_done_i) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (bus_reset_i) begin
                    // A bus reset restarts enumeration; the device stays awake
                    next_state = ST_ACTIVE;
                end else if (bus_suspend_i) begin
                    next_state = ST_SUSPENDED;
                end
            end
            ST_SUSPENDED: begin
                if (bus_resume_i || bus_reset_i) begin
                    next_state = ST_ACTIVE;
                end else if (wake_mismatch && remote_wake_en) begin
                    next_state = ST_WAKING;
                end else if (wake_mismatch) begin
                    // Without host permission no signalling goes out; resume locally
                    next_state = ST_ACTIVE;
                end
            end
            ST_WAKING: begin
                // Signalling generated counts as resume; the host answers with resume
                next_state = ST_ACTIVE;
            end
            default: begin
                next_state = ST_UNCONFIGURED;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_UNCONFIGURED;
        end else begin
            state <= next_state;
        end
    end

    // Indicator high before enumeration and while suspended
    assign next_suspended = (next_state == ST_UNCONFIGURED)
                          || (next_state == ST_SUSPENDED);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            suspended <= 1'b1;
        end else begin
            suspended <= next_suspended;
        end
    end

    // Indicator levels follow the next state so they move with the state flop
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            suspend_o   <= 1'b1;
            suspend_n_o <= 1'b0;
        end else begin
            suspend_o   <= next_suspended;
            suspend_n_o <= ~next_suspended;
        end
    end

    // Indicator pins: released during reset so the weak pull holds them
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            suspend_oe_o   <= 1'b0;
            suspend_n_oe_o <= 1'b0;
        end else begin
            suspend_oe_o   <= 1'b1;
            suspend_n_oe_o <= 1'b1;
        end
    end

    // One-cycle remote wakeup request toward the USB core
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            remote_wake_o <= 1'b0;
        end else begin
            remote_wake_o <= (state == ST_SUSPENDED) && (next_state == ST_WAKING);
        end
    end

    // Pin drive: the suspend image replaces normal drive while suspended
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gpio_o    <= GPIO_ZERO;
            gpio_oe_o <= GPIO_ZERO;
        end else if (next_state == ST_SUSPENDED) begin
            gpio_o    <= susp_level;
            // Open-drain pins drive only their low level
            gpio_oe_o <= ~susp_od | ~susp_level;
        end else begin
            gpio_o    <= gpio_normal_i;
            gpio_oe_o <= gpio_normal_oe_i;
        end
    end

    // Write decode; an unmapped index raises no strobe, so the write is dropped
    always_comb begin
        wr_control     = 1'b0;
        wr_wake_enable = 1'b0;
        wr_wake_match  = 1'b0;
        wr_susp_level  = 1'b0;
        wr_susp_od     = 1'b0;
        wr_irq_enable  = 1'b0;
        wr_clear       = 1'b0;
        if (reg_wr_i) begin
            if (reg_addr_i == ADDR_CONTROL) begin
                wr_control = 1'b1;
            end else if (reg_addr_i == ADDR_WAKE_ENABLE) begin
                wr_wake_enable = 1'b1;
            end else if (reg_addr_i == ADDR_WAKE_MATCH) begin
                wr_wake_match = 1'b1;
            end else if (reg_addr_i == ADDR_SUSP_LEVEL) begin
                wr_susp_level = 1'b1;
            end else if (reg_addr_i == ADDR_SUSP_OD) begin
                wr_susp_od = 1'b1;
            end else if (reg_addr_i == ADDR_IRQ_ENABLE) begin
                wr_irq_enable = 1'b1;
            end else if (reg_addr_i == ADDR_IRQ_CLEAR) begin
                wr_clear = 1'b1;
            end
        end
    end

    // Configuration registers; they model the programmed one-time image
    // Writable here so any image can be loaded; real silicon loads it once
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            config_done    <= 1'b0;
            remote_wake_en <= 1'b0;
        end else if (wr_control) begin
            config_done    <= reg_wdata_i[CTRL_CONFIG_DONE];
            remote_wake_en <= reg_wdata_i[CTRL_REMOTE_WAKE];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wake_enable <= GPIO_ZERO;
        end else if (wr_wake_enable) begin
            wake_enable <= reg_wdata_i[GPIO_COUNT-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wake_match <= GPIO_ZERO;
        end else if (wr_wake_match) begin
            wake_match <= reg_wdata_i[GPIO_COUNT-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            susp_level <= GPIO_ZERO;
        end else if (wr_susp_level) begin
            susp_level <= reg_wdata_i[GPIO_COUNT-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            susp_od <= GPIO_ZERO;
        end else if (wr_susp_od) begin
            susp_od <= reg_wdata_i[GPIO_COUNT-1:0];
        end
    end

    // Interrupt events; a new event wins over a clear in the same cycle
    always_comb begin
        irq_events                = '0;
        irq_events[IRQ_ENTER]     = (state != ST_SUSPENDED) && (next_state == ST_SUSPENDED);
        irq_events[IRQ_EXIT]      = (state == ST_SUSPENDED) && (next_state != ST_SUSPENDED);
        irq_events[IRQ_WAKE_SENT] = (state == ST_SUSPENDED) && (next_state == ST_WAKING);
    end

    // Write-one-to-clear; the event term is ORed after the clear so it survives
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
        end else if (wr_clear) begin
            irq_status <= (irq_status & ~reg_wdata_i[IRQ_WIDTH-1:0]) | irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= '0;
        end else if (wr_irq_enable) begin
            irq_enable <= reg_wdata_i[IRQ_WIDTH-1:0];
        end
    end

    // Registered so the output comes straight from a flop; one cycle late
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_enable);
        end
    end

    // Read decode; the clear register is write-only and reads as zero
    always_comb begin
        next_rdata = DATA_ZERO;
        if (reg_rd_i) begin
            if (reg_addr_i == ADDR_CONTROL) begin
                next_rdata = {30'h0000_0000, remote_wake_en, config_done};
            end else if (reg_addr_i == ADDR_WAKE_ENABLE) begin
                next_rdata = {21'h00_0000, wake_enable};
            end else if (reg_addr_i == ADDR_WAKE_MATCH) begin
                next_rdata = {21'h00_0000, wake_match};
            end else if (reg_addr_i == ADDR_SUSP_LEVEL) begin
                next_rdata = {21'h00_0000, susp_level};
            end else if (reg_addr_i == ADDR_SUSP_OD) begin
                next_rdata = {21'h00_0000, susp_od};
            end else if (reg_addr_i == ADDR_STATUS) begin
                next_rdata = {18'h0_0000, mismatch_bits, suspended, state};
            end else if (reg_addr_i == ADDR_IRQ_STATUS) begin
                next_rdata = {29'h0000_0000, irq_status};
            end else if (reg_addr_i == ADDR_IRQ_ENABLE) begin
                next_rdata = {29'h0000_0000, irq_enable};
            end
        end
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= DATA_ZERO;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule

`default_nettype wire

//--- suspend_pkg.sv
package suspend_pkg;

    // Pin count of the general-purpose port
    localparam int unsigned GPIO_COUNT = 11;

    // Register indices of the plain register port
    localparam logic [3:0] ADDR_CONTROL     = 4'h0;
    localparam logic [3:0] ADDR_WAKE_ENABLE = 4'h1;
    localparam logic [3:0] ADDR_WAKE_MATCH  = 4'h2;
    localparam logic [3:0] ADDR_SUSP_LEVEL  = 4'h3;
    localparam logic [3:0] ADDR_SUSP_OD     = 4'h4;
    localparam logic [3:0] ADDR_STATUS      = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h6;
    localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CLEAR   = 4'h8;

    // Control register fields
    localparam int unsigned CTRL_CONFIG_DONE = 0;
    localparam int unsigned CTRL_REMOTE_WAKE = 1;

    // Interrupt event bits
    localparam int unsigned IRQ_WIDTH       = 3;
    localparam int unsigned IRQ_ENTER       = 0;
    localparam int unsigned IRQ_EXIT        = 1;
    localparam int unsigned IRQ_WAKE_SENT   = 2;

    localparam logic [GPIO_COUNT-1:0] GPIO_ZERO = 11'h000;
    localparam logic [31:0]           DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_UNCONFIGURED = 2'b00,
        ST_ACTIVE       = 2'b01,
        ST_SUSPENDED    = 2'b10,
        ST_WAKING       = 2'b11
    } susp_state_t;

endpackage

//--- usb_suspend_wakeup_control_checker.sv
`timescale 1ns/100ps
`default_nettype none
module usb_suspend_wakeup_control_checker (
    // Clock, reset and bus events
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic bus_suspend_i,
    input wire logic bus_reset_i,
    input wire logic enum_done_i,
    // Indicators and wakeup
    input wire logic remote_wake_o,
    input wire logic suspend_o,
    input wire logic suspend_oe_o,
    input wire logic suspend_n_o,
    input wire logic suspend_n_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_inv; suspend_n_o == !suspend_o; endproperty
    a_inv: assert property (p_inv) else $error("indicators not inverse");
    property p_oe; suspend_oe_o == suspend_n_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("indicator enables differ");
    // Reset must float the active-high indicator even though the other checks sleep then
    property p_float; disable iff (1'b0) !arst_n_i |-> !suspend_oe_o; endproperty
    a_float: assert property (p_float) else $error("indicator driven in reset");
    property p_enter;
        !suspend_o && bus_suspend_i && !bus_reset_i && !remote_wake_o |=> suspend_o;
    endproperty
    a_enter: assert property (p_enter) else $error("suspend not entered");
    property p_unconf; !enum_done_i |=> suspend_o && !suspend_n_o; endproperty
    a_unconf: assert property (p_unconf) else $error("indicator low before enumeration");
    property p_wexit; remote_wake_o |-> !suspend_o; endproperty
    a_wexit: assert property (p_wexit) else $error("still suspended at wakeup");
    property p_wpulse; remote_wake_o |=> !remote_wake_o; endproperty
    a_wpulse: assert property (p_wpulse) else $error("wakeup pulse too long");
    property p_wcause; remote_wake_o |-> $past(suspend_o); endproperty
    a_wcause: assert property (p_wcause) else $error("wakeup while not suspended");
endmodule
bind usb_suspend_wakeup_control usb_suspend_wakeup_control_checker chk (.*);
`default_nettype wire

//--- usb_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
    // Clock and device wakeup
    input  wire logic clk_i,
    input  wire logic remote_wake_i,
    input  wire logic wake_allowed_i,
    // Bus events toward the device
    output logic      bus_suspend_o,
    output logic      bus_resume_o,
    output logic      bus_reset_o,
    output logic      enum_done_o
);
    int lag = 0;
    initial {bus_reset_o, bus_resume_o, bus_suspend_o, enum_done_o} = 4'h0;
    // One-cycle event: 0 suspend, 1 resume, 2 bus reset
    task automatic signal(input int k);
        @(posedge clk_i);
        {bus_reset_o, bus_resume_o, bus_suspend_o} <= 3'h1 << k;
        @(posedge clk_i);
        {bus_reset_o, bus_resume_o, bus_suspend_o} <= 3'h0;
    endtask
    // Only a host that enabled wakeup answers it; lag models a slow host
    always @(posedge clk_i) begin
        if (remote_wake_i && wake_allowed_i) begin
            repeat (lag) @(posedge clk_i);
            signal(1);
        end
    end
endmodule
`default_nettype wire

//--- usb_suspend_wakeup_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module usb_suspend_wakeup_control_tb_top;
    import suspend_pkg::*;
    logic                  clk_i = 1'b0;
    logic                  arst_n_i = 1'b1;
    logic                  reg_wr_i = 1'b0;
    logic                  reg_rd_i = 1'b0;
    logic                  allow = 1'b0;
    logic                  sus, sus_n, oe, oe_n, rw, irq, s_ev, r_ev, b_ev, enum_done;
    logic [3:0]            reg_addr_i = 4'h0;
    logic [31:0]           reg_wdata_i = 32'h0, rdata;
    logic [GPIO_COUNT-1:0] gpio_i = 11'h000, gn = 11'h000, gn_oe = 11'h000, gout, goe;
    logic [15:0]           seed = 16'h0021;
    int                    mismatches = 0, total_checks = 0, wakes = 0;

    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (rw) wakes <= wakes + 1;

    usb_suspend_wakeup_control dut (.clk_i, .arst_n_i, .bus_suspend_i(s_ev),
        .bus_resume_i(r_ev), .bus_reset_i(b_ev), .enum_done_i(enum_done), .remote_wake_o(rw),
        .gpio_i, .gpio_normal_i(gn), .gpio_normal_oe_i(gn_oe), .gpio_o(gout), .gpio_oe_o(goe),
        .suspend_o(sus), .suspend_oe_o(oe), .suspend_n_o(sus_n), .suspend_n_oe_o(oe_n),
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata), .irq_o(irq));
    usb_host_model host (.clk_i, .remote_wake_i(rw), .wake_allowed_i(allow),
        .bus_suspend_o(s_ev), .bus_resume_o(r_ev), .bus_reset_o(b_ev), .enum_done_o(enum_done));

    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Open-drain pins release the line when their level is high
    function automatic logic [10:0] exp_oe(input logic [10:0] lvl, od);
        return ~(od & lvl);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        logic [10:0] en, mt, lvl, od;
        int w0;
        // A real edge at time zero so every reset flop starts known
        arst_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        tick(3);
        chk("oe", 1, oe);
        wr(ADDR_CONTROL, 32'h1);
        tick(4);
        chk("suspend", 1, sus);
        wr(ADDR_IRQ_ENABLE, 32'h7);
        host.enum_done_o <= 1'b1;
        tick(2);
        chk("suspend", 0, sus);
        chk("suspend_n", 1, sus_n);
        rd(4'hf, 0, "unmapped");
        rd(ADDR_IRQ_CLEAR, 0, "clear reg");
        chk("irq", 0, irq);
        for (int i = 0; i < 11; i++) begin
            seed = nx(seed);
            en = seed[10:0] | (11'h001 << i);
            seed = nx(seed);
            mt = seed[10:0];
            seed = nx(seed);
            lvl = seed[10:0];
            od = seed[15:5] ^ mt;
            allow <= i[0];
            host.lag = i % 3;
            gpio_i <= mt;
            gn <= lvl ^ en;
            gn_oe <= od;
            wr(ADDR_CONTROL, {30'h0, i[0], 1'b1});
            wr(ADDR_WAKE_ENABLE, {21'h0, en});
            wr(ADDR_WAKE_MATCH, {21'h0, mt});
            wr(ADDR_SUSP_LEVEL, {21'h0, lvl});
            wr(ADDR_SUSP_OD, {21'h0, od});
            wr(ADDR_IRQ_CLEAR, 32'h7);
            host.signal(0);
            tick(1);
            chk("suspend", 1, sus);
            chk("gpio out", lvl, gout);
            chk("gpio oe", exp_oe(lvl, od), goe);
            rd(ADDR_IRQ_STATUS, 32'h1, "irq status");
            chk("irq", 1, irq);
            gpio_i <= mt ^ ~en;
            tick(4);
            chk("suspend", 1, sus);
            w0 = wakes;
            gpio_i <= mt ^ ~en ^ (11'h001 << i);
            tick(3);
            chk("suspend", 0, sus);
            chk("wakeups", i[0], wakes - w0);
            chk("gpio out", lvl ^ en, gout);
            chk("gpio oe", od, goe);
            gpio_i <= mt;
            tick(4);
        end
        host.signal(0);
        tick(1);
        host.signal(1);
        tick(1);
        chk("suspend", 0, sus);
        host.signal(0);
        tick(1);
        wr(ADDR_IRQ_CLEAR, 32'h7);
        host.signal(2);
        tick(1);
        rd(ADDR_IRQ_STATUS, 32'h2, "irq status");
        arst_n_i <= 1'b0;
        host.enum_done_o <= 1'b0;
        tick(1);
        chk("oe_n", 0, oe_n);
        arst_n_i <= 1'b1;
        tick(3);
        chk("suspend", 1, sus);
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
